// ===== hdl/xcs_defines.svh
// Address map, register bits and timing constants for the chip-select decoder
// Functional notes
// R1: Slow regions stretch both bus clock phases
// R2: Speed control register selects stretching; cache fast
// R3: Every 24-bit address decodes to one target
// R4: Enabled on-chip ROM hides E000-FFFF from ROM
// R5: Page DF00-DFFF never selects ROM or low
// R6: Low select excludes ROM, cache, on-chip space
// R7: Expansion, coprocessor space excludes on-chip, ROM, low
// R8: Cache covers 0200-7FFF or 0000-7FFF by bit
// R9: Port expansion select gated by bus control bit
// R10: Bank selects, coprocessor select, active low
`ifndef XCS_DEFINES_SVH
`define XCS_DEFINES_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define XCS_ADDR_BUS_CONTROL  24'h00df40
`define XCS_ADDR_SPEED_CTRL   24'h00df41
`define XCS_ADDR_PORT7_SEL    24'h00df27
`define XCS_RST_BUS_CONTROL   8'h00
`define XCS_RST_SPEED_CTRL    8'h00
`define XCS_RST_PORT7_SEL     8'h00

// ---------------------------------------------------------------
// Register bits
// ---------------------------------------------------------------
`define XCS_BIT_EXT_BUS   0
`define XCS_BIT_ROM_OFF   7
`define XCS_BIT_EXT_RAM   2
`define XCS_BIT_SLOW_EN   3
`define XCS_BIT_STRETCH   7

// ---------------------------------------------------------------
// Map boundaries
// ---------------------------------------------------------------
`define XCS_BANK_ZERO     8'h00
`define XCS_BANK_LOW_TOP  8'h3f
`define XCS_BANK_MID_TOP  8'hbf
`define XCS_PAGE_IO       8'hdf
`define XCS_RAM_TOP       16'h01ff
`define XCS_CACHE_TOP     16'h7fff
`define XCS_ROM_TOP       16'hffff
`define XCS_ROM_INT_BASE  16'he000
`define XCS_PORT_EXP_TOP  16'hdf1f
`define XCS_COPROC_BASE   16'hdfc0

// ---------------------------------------------------------------
// Timing, in rising edges of the fast input clock
// ---------------------------------------------------------------
`define XCS_FAST_HALF     4'h1
`define XCS_SLOW_HALF     4'h4

`endif

// ===== hdl/xcs_pkg.sv
// Types shared by the chip-select decoder modules
`default_nettype none

package xcs_pkg;

	// Active-high selects, bit i is chip select i
	typedef struct packed {
		logic user_high;
		logic user_mid;
		logic low_mem;
		logic rom;
		logic cache;
		logic onchip;
		logic coproc;
		logic port_exp;
	} xcs_sel_t;

	// Configuration bits that steer the decode and the bus clock stretching
	typedef struct packed {
		logic ext_bus;
		logic ext_ram;
		logic rom_off;
		logic slow_en;
	} xcs_cfg_t;

endpackage : xcs_pkg

`default_nettype wire

// ===== hdl/xcs_decode.sv
// Combinational decode of the 24-bit address into region selects
`default_nettype none
`include "xcs_defines.svh"

module xcs_decode
	import xcs_pkg::*;
(
	// Address and configuration
	input  wire logic [23:0] addr,
	input  wire xcs_cfg_t    cfg,
	// Decoded regions
	output xcs_sel_t         sel
);

	logic [7:0]  bank;
	logic [15:0] ofs;
	logic        bank0;
	logic        io_page;
	logic        in_port;
	logic        in_cop;
	logic        rom_int;
	logic        ram_int;

	assign bank = addr[23:16];
	assign ofs  = addr[15:0];

	// Region terms inside bank zero
	always_comb begin
		bank0   = (bank == `XCS_BANK_ZERO);
		io_page = bank0 && (ofs[15:8] == `XCS_PAGE_IO);
		// R9: expansion only with external bus
		in_port = io_page && cfg.ext_bus && (ofs <= `XCS_PORT_EXP_TOP);
		in_cop  = io_page && (ofs >= `XCS_COPROC_BASE);
		// R4: internal ROM hides top 8K
		rom_int = bank0 && !cfg.rom_off && (ofs >= `XCS_ROM_INT_BASE);
		ram_int = bank0 && !cfg.ext_ram && (ofs <= `XCS_RAM_TOP);
	end

	// One target per address; priority keeps regions disjoint
	always_comb begin
		sel          = '0;
		// R7: expansion and coprocessor own their space
		sel.port_exp = in_port;
		sel.coproc   = in_cop;
		sel.onchip   = (io_page && !in_port && !in_cop) || rom_int || ram_int;
		// R8: cache range by external RAM bit
		sel.cache    = bank0 && !ram_int && (ofs <= `XCS_CACHE_TOP);
		// R5: IO page never reaches ROM
		sel.rom      = bank0 && (ofs > `XCS_CACHE_TOP) && !io_page && !rom_int;
		// R3: remaining banks by range
		// R6: bank zero is fully claimed above
		sel.low_mem  = !bank0 && (bank <= `XCS_BANK_LOW_TOP);
		// R10: user memory banks
		sel.user_mid = (bank > `XCS_BANK_LOW_TOP) && (bank <= `XCS_BANK_MID_TOP);
		sel.user_high = (bank > `XCS_BANK_MID_TOP);
	end

endmodule : xcs_decode

`default_nettype wire

// ===== hdl/xcs_phase_gen.sv
// Bus phase clock generator with per-access stretching
`default_nettype none
`include "xcs_defines.svh"

module xcs_phase_gen #(
	parameter logic [3:0] SLOW_HALF = `XCS_SLOW_HALF
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Fast clock edge and stretch request
	input  wire logic fast_rise,
	input  wire logic slow,
	// Generated phase clock
	output logic      phase_clk,
	output logic      stretching,
	output logic      low_start
);

	logic [3:0] cnt;
	logic [3:0] half_len;

	assign half_len = stretching ? SLOW_HALF : `XCS_FAST_HALF;

	// Count fast edges, toggle at the end of each half
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt       <= 4'h0;
			phase_clk <= 1'b0;
			low_start <= 1'b0;
		end else begin
			low_start <= 1'b0;
			if (fast_rise) begin
				if (cnt + 4'h1 >= half_len) begin
					cnt       <= 4'h0;
					phase_clk <= ~phase_clk;
					low_start <= phase_clk;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end

	// Stretch chosen at each fall, held for both halves
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stretching <= 1'b0;
		end else if (fast_rise && phase_clk && (cnt + 4'h1 >= half_len)) begin
			// R1: low and high both stretched
			stretching <= slow;
		end
	end

endmodule : xcs_phase_gen

`default_nettype wire

// ===== hdl/xcs_top.sv
// External chip-select decoder with cache speed control
`default_nettype none
`include "xcs_defines.svh"

module xcs_top
	import xcs_pkg::*;
#(
	parameter logic [3:0] SLOW_HALF = `XCS_SLOW_HALF
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Fast input clock from the board
	input  wire logic        fast_input_clock,
	// Processor address and data
	input  wire logic [23:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	output logic             cpu_rdata_valid,
	output logic             onchip_hit,
	// Chip selects, active low
	output logic             port_expansion_select_n,
	output logic             coprocessor_select_n,
	output logic             onchip_region_select_n,
	output logic             cache_memory_select_n,
	output logic             rom_select_n,
	output logic             low_memory_select_n,
	output logic             user_memory_mid_select_n,
	output logic             user_memory_high_select_n,
	// Bus clock
	output logic             bus_phase_clock
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0] bus_control;
	logic [7:0] system_speed_control;
	logic [7:0] port_seven_select_enable;
	logic       fast_meta;
	logic       fast_sync;
	logic       fast_prev;
	logic       fast_rise;
	xcs_cfg_t   cfg;
	xcs_sel_t   sel;
	logic [7:0] sel_bits;
	logic [7:0] next_sel_n;
	logic       slow;
	logic       stretching;
	logic       phase_clk;
	logic       hit_bus_ctl;
	logic       hit_speed;
	logic       hit_port7;
	logic [7:0] next_rdata;

	// ---------------------------------------------------------------
	// Fast input clock sampling
	// ---------------------------------------------------------------

	// Two stages before any logic looks at the pin
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fast_meta <= 1'b0;
			fast_sync <= 1'b0;
		end else begin
			fast_meta <= fast_input_clock;
			fast_sync <= fast_meta;
		end
	end

	// Edge detect on the settled copy only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fast_prev <= 1'b0;
		end else begin
			fast_prev <= fast_sync;
		end
	end

	assign fast_rise = fast_sync && !fast_prev;

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------

	// Register hits; full address compare
	assign hit_bus_ctl = (cpu_addr == `XCS_ADDR_BUS_CONTROL);
	assign hit_speed   = (cpu_addr == `XCS_ADDR_SPEED_CTRL);
	assign hit_port7   = (cpu_addr == `XCS_ADDR_PORT7_SEL);

	// Bus control: expansion bus and ROM enable
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_control <= `XCS_RST_BUS_CONTROL;
		end else if (cpu_wr && hit_bus_ctl) begin
			bus_control <= cpu_wdata;
		end
	end

	// Speed control: RAM location and stretching
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			system_speed_control <= `XCS_RST_SPEED_CTRL;
		end else if (cpu_wr && hit_speed) begin
			system_speed_control <= cpu_wdata;
		end
	end

	// Per-select pin enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port_seven_select_enable <= `XCS_RST_PORT7_SEL;
		end else if (cpu_wr && hit_port7) begin
			port_seven_select_enable <= cpu_wdata;
		end
	end

	// Configuration seen by the decoder
	always_comb begin
		// R9: expansion bus enable bit
		cfg.ext_bus = bus_control[`XCS_BIT_EXT_BUS];
		cfg.rom_off = bus_control[`XCS_BIT_ROM_OFF];
		// R8: internal or external low RAM
		cfg.ext_ram = system_speed_control[`XCS_BIT_EXT_RAM];
		// R2: stretching enabled by speed control
		cfg.slow_en = system_speed_control[`XCS_BIT_SLOW_EN];
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	xcs_decode u_decode (
		.addr (cpu_addr),
		.cfg  (cfg),
		.sel  (sel)
	);

	assign sel_bits = sel;

	// Pin enables gate each select; disabled pins stay high
	always_comb begin
		// R10: selects driven low when active
		next_sel_n = ~(sel_bits & port_seven_select_enable);
	end

	// Registered select pins, all idle during reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			user_memory_high_select_n <= 1'b1;
			user_memory_mid_select_n  <= 1'b1;
			low_memory_select_n       <= 1'b1;
			rom_select_n              <= 1'b1;
			cache_memory_select_n     <= 1'b1;
			onchip_region_select_n    <= 1'b1;
			coprocessor_select_n      <= 1'b1;
			port_expansion_select_n   <= 1'b1;
		end else begin
			user_memory_high_select_n <= next_sel_n[7];
			user_memory_mid_select_n  <= next_sel_n[6];
			low_memory_select_n       <= next_sel_n[5];
			rom_select_n              <= next_sel_n[4];
			cache_memory_select_n     <= next_sel_n[3];
			onchip_region_select_n    <= next_sel_n[2];
			coprocessor_select_n      <= next_sel_n[1];
			port_expansion_select_n   <= next_sel_n[0];
		end
	end

	// On-chip hit is internal, so it ignores the pin enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			onchip_hit <= 1'b0;
		end else begin
			onchip_hit <= sel.onchip;
		end
	end

	// ---------------------------------------------------------------
	// Bus clock stretching
	// ---------------------------------------------------------------

	// Cache and on-chip space run at full rate
	always_comb begin
		// R2: only non-cache space slows
		slow = cfg.slow_en && !sel.cache && !sel.onchip;
	end

	xcs_phase_gen #(
		.SLOW_HALF (SLOW_HALF)
	) u_phase (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.fast_rise  (fast_rise),
		.slow       (slow),
		.phase_clk  (phase_clk),
		.stretching (stretching),
		.low_start  ()
	);

	// Extra stage keeps the pin straight off a flip-flop
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_phase_clock <= 1'b0;
		end else begin
			bus_phase_clock <= phase_clk;
		end
	end

	// ---------------------------------------------------------------
	// Register read-back
	// ---------------------------------------------------------------

	// Speed control top bit shows live stretching state
	always_comb begin
		next_rdata = 8'h00;
		if (hit_bus_ctl) begin
			next_rdata = bus_control;
		end else if (hit_speed) begin
			next_rdata = system_speed_control;
			next_rdata[`XCS_BIT_STRETCH] = stretching;
		end else if (hit_port7) begin
			next_rdata = port_seven_select_enable;
		end
	end

	// Read data one cycle after the request
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cpu_rdata       <= 8'h00;
			cpu_rdata_valid <= 1'b0;
		end else begin
			cpu_rdata_valid <= cpu_rd && (hit_bus_ctl || hit_speed || hit_port7);
			if (cpu_rd) begin
				cpu_rdata <= next_rdata;
			end
		end
	end

endmodule : xcs_top

`default_nettype wire

// ===== sim/xcs_board_model.sv
// Board side model: free-running fast clock and select activity count
`default_nettype none

module xcs_board_model (
	// Board clock
	output var logic       fast_input_clock,
	// Selects seen on the board
	input  wire logic [7:0] sel_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned n_access;
	// Oscillator runs free, offset so its edges never coincide with a core clock edge
	initial begin
		n_access = 0;
		fast_input_clock = 1'b0;
		#7;
		forever #80 fast_input_clock = ~fast_input_clock;
	end
	// One count each time a select goes active after all selects were idle
	always @(negedge (&sel_n)) n_access++;
endmodule : xcs_board_model

`default_nettype wire

// ===== sim/xcs_top_props.sv
// Port checks for the chip-select decoder
`default_nettype none

module xcs_top_props #(
	parameter logic [3:0] SLOW_HALF = 4'h4
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [23:0] cpu_addr,
	input wire logic        cpu_rd,
	input wire logic [7:0]  cpu_rdata,
	input wire logic        cpu_rdata_valid,
	input wire logic        port_expansion_select_n,
	input wire logic        coprocessor_select_n,
	input wire logic        onchip_region_select_n,
	input wire logic        cache_memory_select_n,
	input wire logic        rom_select_n,
	input wire logic        low_memory_select_n,
	input wire logic        user_memory_mid_select_n,
	input wire logic        user_memory_high_select_n,
	input wire logic        bus_phase_clock
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0] act;
	// Active-high view of the selects
	assign act = ~{user_memory_high_select_n, user_memory_mid_select_n, low_memory_select_n,
		rom_select_n, cache_memory_select_n, onchip_region_select_n, coprocessor_select_n,
		port_expansion_select_n};
	sequence s_reg_read;
		cpu_rd && cpu_addr == 24'h00df41;
	endsequence
	sequence s_hole_read;
		cpu_rd && cpu_addr == 24'h00df50;
	endsequence
	a_one_target: assert property ($countones(act) <= 1)
		else $error("two selects active");
	a_coproc_range: assert property (act[1] |-> $past(cpu_addr[23:6]) == 18'h0037f)
		else $error("coprocessor select outside its page");
	a_port_range: assert property (act[0] |-> $past(cpu_addr[23:5]) == 19'h006f8)
		else $error("port expansion select outside its range");
	a_rom_range: assert property (act[4] |->
		$past(cpu_addr[23:15]) == 9'h001 && $past(cpu_addr[15:8]) != 8'hdf)
		else $error("rom select outside upper bank zero");
	a_cache_range: assert property (act[3] |-> $past(cpu_addr[23:15]) == 9'h000)
		else $error("cache select outside lower bank zero");
	a_low_bank: assert property (act[5] |->
		$past(cpu_addr[23:22]) == 2'b00 && $past(cpu_addr[21:16]) != 6'h00)
		else $error("low select outside banks 01 to 3f");
	a_mid_bank: assert property (act[6] |-> $past(cpu_addr[23:22]) inside {2'b01, 2'b10})
		else $error("mid select outside banks 40 to bf");
	a_high_bank: assert property (act[7] |-> $past(cpu_addr[23:22]) == 2'b11)
		else $error("high select outside banks c0 to ff");
	a_read_answer: assert property (s_reg_read |=> cpu_rdata_valid)
		else $error("speed register read not answered");
	a_hole_quiet: assert property (s_hole_read |=> !cpu_rdata_valid && cpu_rdata == 8'h00)
		else $error("unmapped read answered");
	a_phase_min: assert property ($rose(bus_phase_clock) |-> bus_phase_clock[*6])
		else $error("bus clock high phase too short");
	a_phase_max: assert property ($rose(bus_phase_clock) |-> ##[1:60] $fell(bus_phase_clock))
		else $error("bus clock high phase too long");
endmodule : xcs_top_props

`default_nettype wire

// ===== sim/xcs_top_tb_top.sv
// Self-checking bench for the chip-select decoder
`default_nettype none

module xcs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOW = 4;
	localparam logic [23:0] CORNER [0:20] = '{24'h000000, 24'h0001ff, 24'h000200, 24'h007fff,
		24'h008000, 24'h00deff, 24'h00df00, 24'h00df07, 24'h00df1f, 24'h00df20, 24'h00dfbf,
		24'h00dfc0, 24'h00dfff, 24'h00e000, 24'h00ffff, 24'h010000, 24'h3fffff, 24'h400000,
		24'hbfffff, 24'hc00000, 24'hffffff};
	logic        clk_sys, rst, fast_input_clock, cpu_wr, cpu_rd, cpu_rdata_valid, bus_phase_clock;
	logic        onchip_hit;
	logic [23:0] cpu_addr;
	logic [7:0]  cpu_wdata, cpu_rdata, bus_ctl, speed_ctl, pen;
	wire logic [7:0] sel_n;
	logic [31:0] rng;
	int          n_mismatch, cmp_count, lo, hi;

	xcs_top #(.SLOW_HALF(4'(SLOW))) xcs_top_inst (.clk_sys(clk_sys), .rst(rst),
		.fast_input_clock(fast_input_clock), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_rdata_valid(cpu_rdata_valid), .onchip_hit(onchip_hit),
		.port_expansion_select_n(sel_n[0]),
		.coprocessor_select_n(sel_n[1]), .onchip_region_select_n(sel_n[2]),
		.cache_memory_select_n(sel_n[3]), .rom_select_n(sel_n[4]),
		.low_memory_select_n(sel_n[5]), .user_memory_mid_select_n(sel_n[6]),
		.user_memory_high_select_n(sel_n[7]), .bus_phase_clock(bus_phase_clock));
	xcs_board_model xcs_board_model_inst (.fast_input_clock(fast_input_clock), .sel_n(sel_n));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction : xs
	// Expected active-high selects before pin enables, from the map and register copies
	function automatic logic [7:0] exp_sel(input logic [23:0] a);
		logic [7:0] s;
		s = 8'h00;
		if (a[23:22] == 2'b11) s[7] = 1'b1;
		else if (a[23:22] != 2'b00) s[6] = 1'b1;
		else if (a[21:16] != 6'h00) s[5] = 1'b1;
		else if (a[15:9] == 7'h00) s[speed_ctl[2] ? 3 : 2] = 1'b1;
		else if (!a[15]) s[3] = 1'b1;
		else if (a[15:8] == 8'hdf) begin
			if (a[7:5] == 3'h0 && bus_ctl[0]) s[0] = 1'b1;
			else if (a[7:6] == 2'b11) s[1] = 1'b1;
			else s[2] = 1'b1;
		end
		else if (a[15:13] == 3'h7 && !bus_ctl[7]) s[2] = 1'b1;
		else s[4] = 1'b1;
		exp_sel = s;
	endfunction : exp_sel
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Write strobe, then one idle edge so the next strobe is a fresh pulse
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(posedge clk_sys) #2;
		cpu_wr = 1'b0;
		@(posedge clk_sys) #2;
	endtask : wr
	task automatic rd(input logic [23:0] a, input logic [7:0] m, input logic [7:0] e,
		input logic v);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(posedge clk_sys) #2;
		cpu_rd = 1'b0;
		check({7'h00, cpu_rdata_valid}, {7'h00, v}); // Register answer
		check(cpu_rdata & m, e); // Register value
		@(posedge clk_sys) #2;
	endtask : rd
	task automatic probe(input logic [23:0] a);
		logic [7:0] e;
		e = exp_sel(a);
		cpu_addr = a;
		@(posedge clk_sys) #2;
		check(~sel_n, e & pen); // Decode
		check({7'h00, onchip_hit}, {7'h00, e[2]}); // Internal space
	endtask : probe
	// Low and high length of the second full bus clock period, sampled off the edge
	task automatic phase_len(output int lo, output int hi);
		int w;
		w = 0;
		repeat (2) begin
			{lo, hi} = 64'h0;
			while (bus_phase_clock !== 1'b0 && w < 400) begin @(posedge clk_sys) #2; w++; end
			while (bus_phase_clock !== 1'b1 && w < 400) begin @(posedge clk_sys) #2; w++; lo++; end
			while (bus_phase_clock === 1'b1 && w < 400) begin @(posedge clk_sys) #2; w++; hi++; end
		end
		if (w >= 400) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : phase_len

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		{rst, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, bus_ctl, speed_ctl, pen} = {3'b100, 56'h0};
		{n_mismatch, cmp_count, rng} = {64'h0, 32'd17};
		repeat (8) @(posedge clk_sys);
		#2 rst = 1'b0;
		// Reset values and an unmapped read
		rd(24'h00df40, 8'hff, 8'h00, 1'b1); // Bus control reset
		rd(24'h00df41, 8'h7f, 8'h00, 1'b1); // Speed control reset
		rd(24'h00df27, 8'hff, 8'h00, 1'b1); // Pin enables reset
		rd(24'h00df50, 8'hff, 8'h00, 1'b0); // Unmapped read
		probe(24'h400000); // Disabled pins
		// Every decode setting, corners and random addresses
		for (int c = 0; c < 16; c++) begin
			rng = xs(rng);
			pen = (c >= 12) ? rng[7:0] : 8'hff;
			bus_ctl = {c[0], 6'h00, c[1]};
			speed_ctl = {4'h0, c[3], c[2], 2'h0};
			wr(24'h00df27, pen);
			wr(24'h00df40, bus_ctl);
			wr(24'h00df41, speed_ctl);
			rd(24'h00df41, 8'h7f, speed_ctl, 1'b1); // Speed control
			foreach (CORNER[i]) probe(CORNER[i]);
			repeat (12) begin
				rng = xs(rng);
				probe(rng[23:0]);
				probe({8'h00, rng[31:16]});
			end
		end
		// Stretch only for slow regions while enabled, both phases
		wr(24'h00df41, 8'h08);
		cpu_addr = 24'h400000;
		phase_len(lo, hi);
		check({7'h00, hi >= SLOW * 8 - 2 && hi <= SLOW * 8 + 2}, 8'h01); // Slow high
		check({7'h00, lo >= SLOW * 8 - 2 && lo <= SLOW * 8 + 2}, 8'h01); // Slow low
		rd(24'h00df41, 8'hff, 8'h88, 1'b1); // Stretch status set
		cpu_addr = 24'h000300;
		phase_len(lo, hi);
		check({7'h00, hi >= 6 && hi <= 10}, 8'h01); // Cache fast high
		check({7'h00, lo >= 6 && lo <= 10}, 8'h01); // Cache fast low
		rd(24'h00df41, 8'hff, 8'h08, 1'b1); // Stretch status clear
		wr(24'h00df41, 8'h00);
		cpu_addr = 24'h400000;
		phase_len(lo, hi);
		check({7'h00, hi >= 6 && hi <= 10}, 8'h01); // Disabled fast high
		check({7'h00, lo >= 6 && lo <= 10}, 8'h01); // Disabled fast low
		// Second reset in mid-run
		rst = 1'b1;
		{bus_ctl, speed_ctl, pen} = 24'h0;
		repeat (2) @(posedge clk_sys);
		#2 rst = 1'b0;
		check(sel_n, 8'hff); // Idle selects
		rd(24'h00df27, 8'hff, 8'h00, 1'b1); // Pin enables cleared
		rd(24'h00df40, 8'hff, 8'h00, 1'b1); // Bus control cleared
		rd(24'h00df41, 8'hff, 8'h00, 1'b1); // Speed control cleared
		pen = 8'hff;
		wr(24'h00df27, pen);
		probe(24'h000100); // Internal RAM after reset
		probe(24'h00df00); // Expansion off after reset
		check({7'h00, xcs_board_model_inst.n_access != 0}, 8'h01); // Board saw selects
		wrap_up();
	end
endmodule : xcs_top_tb_top

bind xcs_top xcs_top_props #(.SLOW_HALF(SLOW_HALF)) xcs_top_props_inst (.clk_sys(clk_sys),
	.rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
	.cpu_rdata_valid(cpu_rdata_valid), .port_expansion_select_n(port_expansion_select_n),
	.coprocessor_select_n(coprocessor_select_n), .onchip_region_select_n(onchip_region_select_n),
	.cache_memory_select_n(cache_memory_select_n), .rom_select_n(rom_select_n),
	.low_memory_select_n(low_memory_select_n), .user_memory_mid_select_n(user_memory_mid_select_n),
	.user_memory_high_select_n(user_memory_high_select_n), .bus_phase_clock(bus_phase_clock));

`default_nettype wire
